// *** hdl/cpfam_top.sv ***
// stack select and priority flags, address decode and peripheral register area
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "cpfam_map.svh"

module cpfam_top
  import cpfam_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [19:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output cpfam_region_t    mem_region,
  output logic             mem_vector,
  output logic             mem_wr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        flg_wr,
  input  wire logic        flg_u,
  input  wire logic        flg_ie,
  input  wire logic [2:0]  flg_ipl,
  input  wire logic        irq_req,
  input  wire logic [2:0]  irq_prio,
  output logic             irq_ack,
  input  wire logic        trap_exec,
  input  wire logic [5:0]  trap_num,
  input  wire logic        act_sp_wr,
  input  wire logic        isp_wr,
  input  wire logic        usp_wr,
  input  wire logic [15:0] sp_wdata,
  output logic [15:0]      active_sp,
  output logic             sp_in_ram,
  output logic             flag_u,
  output logic             flag_ie,
  output logic [2:0]       flag_ipl,
  output logic             flag_rsv,
  input  wire logic [55:0] port_din,
  output logic [55:0]      port_dout,
  output logic [55:0]      port_oe,
  output logic [7:0]       dac0_value,
  output logic [7:0]       dac1_value,
  output logic [7:0]       dac_ctrl,
  output logic [15:0]      pullup_ctrl
);

  cpfam_state_t  q;
  cpfam_state_t  d;
  cpfam_region_t bus_region;
  cpfam_region_t sp_region;
  logic          bus_vec;
  logic          irq_take;
  logic          trap_take;
  logic [9:0]    ofs;
  logic [2:0]    rd_pd;
  logic [2:0]    rd_pr;
  logic [3:0]    rd_mi;

  function automatic logic [2:0] pdat_idx(input logic [9:0] o);
    case (o)
      `CPFAM_OFS_PDAT0: pdat_idx = 3'h0;
      `CPFAM_OFS_PDAT1: pdat_idx = 3'h1;
      `CPFAM_OFS_PDAT2: pdat_idx = 3'h2;
      `CPFAM_OFS_PDAT3: pdat_idx = 3'h3;
      `CPFAM_OFS_PDAT4: pdat_idx = 3'h4;
      `CPFAM_OFS_PDAT5: pdat_idx = 3'h5;
      `CPFAM_OFS_PDAT6: pdat_idx = 3'h6;
      default:          pdat_idx = 3'h7;
    endcase
  endfunction

  function automatic logic [2:0] pdir_idx(input logic [9:0] o);
    case (o)
      `CPFAM_OFS_PDIR0: pdir_idx = 3'h0;
      `CPFAM_OFS_PDIR1: pdir_idx = 3'h1;
      `CPFAM_OFS_PDIR2: pdir_idx = 3'h2;
      `CPFAM_OFS_PDIR3: pdir_idx = 3'h3;
      `CPFAM_OFS_PDIR4: pdir_idx = 3'h4;
      `CPFAM_OFS_PDIR5: pdir_idx = 3'h5;
      `CPFAM_OFS_PDIR6: pdir_idx = 3'h6;
      default:          pdir_idx = 3'h7;
    endcase
  endfunction

  function automatic logic [3:0] misc_idx(input logic [9:0] o);
    case (o)
      `CPFAM_OFS_DAC0:   misc_idx = 4'h0;
      `CPFAM_OFS_DAC1:   misc_idx = 4'h1;
      `CPFAM_OFS_DAC_CONTROL:  misc_idx = 4'h2;
      `CPFAM_OFS_P2DRV:  misc_idx = 4'h3;
      `CPFAM_OFS_SER1FS: misc_idx = 4'h4;
      `CPFAM_OFS_PMODE:  misc_idx = 4'h5;
      `CPFAM_OFS_XIRQEN: misc_idx = 4'h6;
      `CPFAM_OFS_IRQFLT: misc_idx = 4'h7;
      `CPFAM_OFS_KEYEN:  misc_idx = 4'h8;
      `CPFAM_OFS_PUP0:   misc_idx = 4'h9;
      `CPFAM_OFS_PUP1:   misc_idx = 4'ha;
      default:           misc_idx = 4'hf;
    endcase
  endfunction

  cpfam_addr_dec u_bus_dec (
    .addr      (reg_addr),
    .region    (bus_region),
    .is_vector (bus_vec)
  );

  cpfam_addr_dec u_sp_dec (
    .addr      ({4'h0, active_sp}),
    .region    (sp_region),
    .is_vector ()
  );

  assign ofs   = reg_addr[9:0];
  assign rd_pd = pdat_idx(ofs);
  assign rd_pr = pdir_idx(ofs);
  assign rd_mi = misc_idx(ofs);

  assign irq_take  = irq_req && q.ie && (irq_prio > q.processor_priority_level);
  assign trap_take = trap_exec && (trap_num <= `CPFAM_TRAP_MAX);
  assign irq_ack   = irq_take;

  assign mem_region = bus_region;
  assign mem_vector = bus_vec;
  assign mem_wr     = reg_wr && (bus_region == REG_RAM);
  assign mem_rd     = reg_rd && (bus_region inside {REG_RAM, REG_FLASH, REG_ROM});

  always_comb begin
    d        = q;
    d.pin_s1 = port_din;
    d.pin_s2 = q.pin_s1;
    d.rdata  = `CPFAM_UNDEF_RD;
    if (reg_wr && bus_region == REG_SFR) begin
      if (rd_pd != 3'h7) begin
        d.pdat[rd_pd] = reg_wdata;
      end
      if (rd_pr != 3'h7) begin
        d.pdir[rd_pr] = reg_wdata;
      end
      if (rd_mi != 4'hf) begin
        d.misc[rd_mi] = reg_wdata;
      end
    end
    if (reg_rd) begin
      unique case (bus_region)
        REG_NONE: d.rdata = `CPFAM_UNDEF_RD;
        REG_SFR: begin
          if (rd_pd != 3'h7) begin
            d.rdata = (q.pdir[rd_pd] & q.pdat[rd_pd])
                    | (~q.pdir[rd_pd] & q.pin_s2[rd_pd]);
          end else if (rd_pr != 3'h7) begin
            d.rdata = q.pdir[rd_pr];
          end else if (rd_mi != 4'hf) begin
            d.rdata = q.misc[rd_mi];
          end
        end
        REG_RAM,
        REG_FLASH,
        REG_ROM: d.rdata = mem_rdata;
      endcase
    end
    if (flg_wr) begin
      d.u   = flg_u;
      d.ie  = flg_ie;
      d.processor_priority_level = flg_ipl;
    end
    if (irq_take || trap_take) begin
      d.u = 1'b0;
    end
    if (irq_take) begin
      d.ie = 1'b0;
    end
    if (isp_wr) begin
      d.interrupt_stack_pointer = sp_wdata;
    end
    if (usp_wr) begin
      d.user_stack_pointer = sp_wdata;
    end
    if (act_sp_wr) begin
      if (q.u) begin
        d.user_stack_pointer = sp_wdata;
      end else begin
        d.interrupt_stack_pointer = sp_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // direction clears, data taken as zero
      q.pdat   <= {7{`CPFAM_RST_PDAT}};
      q.pdir   <= {7{`CPFAM_RST_PDIR}};
      q.misc   <= {11{`CPFAM_RST_REG}};
      q.pin_s1 <= {7{`CPFAM_RST_PDAT}};
      q.pin_s2 <= {7{`CPFAM_RST_PDAT}};
      q.interrupt_stack_pointer    <= `CPFAM_RST_SP;
      q.user_stack_pointer    <= `CPFAM_RST_SP;
      q.u      <= `CPFAM_RST_FLAG;
      q.ie     <= `CPFAM_RST_FLAG;
      q.processor_priority_level    <= `CPFAM_RST_IPL;
      q.rdata  <= `CPFAM_UNDEF_RD;
    end else begin
      q <= d;
    end
  end

  assign active_sp   = q.u ? q.user_stack_pointer : q.interrupt_stack_pointer;
  assign sp_in_ram   = (sp_region == REG_RAM);
  assign reg_rdata   = q.rdata;
  assign flag_u      = q.u;
  assign flag_ie     = q.ie;
  assign flag_ipl    = q.processor_priority_level;
  assign flag_rsv    = 1'b0;
  assign port_dout   = q.pdat;
  assign port_oe     = q.pdir;
  assign dac0_value  = q.misc[0];
  assign dac1_value  = q.misc[1];
  assign dac_ctrl    = q.misc[2];
  assign pullup_ctrl = {q.misc[10], q.misc[9]};

  sequence sp_write_s;
    act_sp_wr && !isp_wr && !usp_wr && !flg_wr && !irq_take && !trap_take;
  endsequence

  sequence dir_write_s;
    reg_wr && bus_region == REG_SFR && rd_pr != 3'h7;
  endsequence

  sequence same_dir_read_s;
    reg_rd && rd_pr == $past(rd_pr) && bus_region == REG_SFR;
  endsequence

  active_sp_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    sp_write_s |=> active_sp == $past(sp_wdata))
    else $error("active stack pointer did not take the write");

  u_clear_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (irq_ack || (trap_exec && trap_num <= 6'h1f)) |=> !flag_u)
    else $error("stack select not cleared");

  trap_keep_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (trap_exec && trap_num > 6'h1f && !irq_ack && !flg_wr) |=> $stable(flag_u))
    else $error("high trap changed stack select");

  ipl_load_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    flg_wr |=> flag_ipl == $past(flg_ipl))
    else $error("priority level not loaded");

  prio_gate_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    irq_ack |-> (irq_prio > flag_ipl) && irq_req)
    else $error("interrupt taken without higher priority");

  ie_clear_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    irq_ack |=> !flag_ie ##1 (!flag_ie || $past(flg_wr)))
    else $error("enable flag not cleared on ack");

  ie_block_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !flag_ie |-> !irq_ack)
    else $error("interrupt taken while disabled");

  unmapped_read_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (reg_rd && bus_region == REG_NONE) |-> !mem_rd ##1 reg_rdata == `CPFAM_UNDEF_RD)
    else $error("unmapped read gave data");

  wr_ignored_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (reg_wr && bus_region != REG_RAM) |-> !mem_wr)
    else $error("write escaped to memory outside ram");

  rdata_idle_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !reg_rd |=> reg_rdata == `CPFAM_UNDEF_RD)
    else $error("read data held past its cycle");

  dir_readback_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    dir_write_s ##1 same_dir_read_s |=> reg_rdata == $past(reg_wdata, 2))
    else $error("direction register readback wrong");

  flash_map_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (reg_rd && reg_addr >= 20'h02400 && reg_addr <= 20'h02bff)
      |-> mem_rd && mem_region == REG_FLASH)
    else $error("flash window misdecoded");

  vector_map_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    mem_vector |-> mem_region == REG_ROM && reg_addr >= 20'h0ffdc)
    else $error("vector table misdecoded");

  ram_base_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (reg_wr && reg_addr == 20'h00400) |-> mem_wr)
    else $error("ram base not decoded");

endmodule // cpfam_top

// *** include/cpfam_map.svh ***
// address map, register offsets, reset values and limits for the flag and map block
`ifndef CPFAM_MAP_SVH
`define CPFAM_MAP_SVH

`define CPFAM_ADDR_MIN   20'h00000
`define CPFAM_ADDR_MAX   20'hfffff
`define CPFAM_SFR_LO     20'h00000
`define CPFAM_SFR_HI     20'h002ff
`define CPFAM_RAM_LO     20'h00400
`define CPFAM_RAM_HI     20'h00dff
`define CPFAM_FLASH_LO   20'h02400
`define CPFAM_FLASH_HI   20'h02bff
`define CPFAM_ROM_LO     20'h04000
`define CPFAM_ROM_HI     20'h0ffff
`define CPFAM_VEC_LO     20'h0ffdc
`define CPFAM_VEC_HI     20'h0ffff

`define CPFAM_OFS_DAC0   10'h0d8
`define CPFAM_OFS_DAC1   10'h0da
`define CPFAM_OFS_DAC_CONTROL  10'h0dc
`define CPFAM_OFS_PDAT0  10'h0e0
`define CPFAM_OFS_PDAT1  10'h0e1
`define CPFAM_OFS_PDIR0  10'h0e2
`define CPFAM_OFS_PDIR1  10'h0e3
`define CPFAM_OFS_PDAT2  10'h0e4
`define CPFAM_OFS_PDAT3  10'h0e5
`define CPFAM_OFS_PDIR2  10'h0e6
`define CPFAM_OFS_PDIR3  10'h0e7
`define CPFAM_OFS_PDAT4  10'h0e8
`define CPFAM_OFS_PDAT5  10'h0e9
`define CPFAM_OFS_PDIR4  10'h0ea
`define CPFAM_OFS_PDIR5  10'h0eb
`define CPFAM_OFS_PDAT6  10'h0ec
`define CPFAM_OFS_PDIR6  10'h0ee
`define CPFAM_OFS_P2DRV  10'h0f4
`define CPFAM_OFS_SER1FS 10'h0f5
`define CPFAM_OFS_PMODE  10'h0f8
`define CPFAM_OFS_XIRQEN 10'h0f9
`define CPFAM_OFS_IRQFLT 10'h0fa
`define CPFAM_OFS_KEYEN  10'h0fb
`define CPFAM_OFS_PUP0   10'h0fc
`define CPFAM_OFS_PUP1   10'h0fd

`define CPFAM_RST_REG    8'h00
`define CPFAM_RST_PDAT   8'h00
`define CPFAM_RST_PDIR   8'h00
`define CPFAM_RST_SP     16'h0000
`define CPFAM_RST_IPL    3'h0
`define CPFAM_RST_FLAG   1'b0
`define CPFAM_UNDEF_RD   8'h00
`define CPFAM_TRAP_MAX   6'h1f

`endif

// *** include/cpfam_pkg.sv ***
// types shared by the flag and address map block
package cpfam_pkg;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_SFR,
    REG_RAM,
    REG_FLASH,
    REG_ROM
  } cpfam_region_t;

  typedef struct packed {
    logic [6:0][7:0]  pdat;
    logic [6:0][7:0]  pdir;
    logic [10:0][7:0] misc;
    logic [6:0][7:0]  pin_s1;
    logic [6:0][7:0]  pin_s2;
    logic [15:0]      interrupt_stack_pointer;
    logic [15:0]      user_stack_pointer;
    logic             u;
    logic             ie;
    logic [2:0]       processor_priority_level;
    logic [7:0]       rdata;
  } cpfam_state_t;

endpackage

// *** hdl/cpfam_addr_dec.sv ***
// decoder of the 1-Mbyte space into memory regions
`timescale 1ns/1ps
`include "cpfam_map.svh"

module cpfam_addr_dec
  import cpfam_pkg::*;
(
  input  wire logic [19:0] addr,
  output cpfam_region_t    region,
  output logic             is_vector
);

  always_comb begin
    region = REG_NONE;
    if (addr >= `CPFAM_SFR_LO && addr <= `CPFAM_SFR_HI) begin
      region = REG_SFR;
    end
    if (addr >= `CPFAM_RAM_LO && addr <= `CPFAM_RAM_HI) begin
      region = REG_RAM;
    end
    if (addr >= `CPFAM_FLASH_LO && addr <= `CPFAM_FLASH_HI) begin
      region = REG_FLASH;
    end
    if (addr >= `CPFAM_ROM_LO && addr <= `CPFAM_ROM_HI) begin
      region = REG_ROM;
    end
  end

  assign is_vector = (addr >= `CPFAM_VEC_LO) && (addr <= `CPFAM_VEC_HI);

endmodule // cpfam_addr_dec

// *** bench/cpfam_mem_model.sv ***
// memory array model on the far side of the block's memory port
`timescale 1ns/1ps

module cpfam_mem_model (
  input  wire logic        sys_clk,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [7:0]       rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_q;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
    last_q = 8'h00;
  end

  always @(posedge sys_clk) begin
    if (wr) begin
      mem[addr[7:0]] <= wdata;
    end
    if (rd) begin
      last_q <= mem[addr[7:0]];
    end
  end

  // released bus shows inverse of last value
  assign rdata = rd ? mem[addr[7:0]] : ~last_q;
endmodule // cpfam_mem_model

// *** bench/cpu_flag_and_address_map_test.sv ***
// self-checking bench for the flag and address map block
`timescale 1ns/1ps

module cpu_flag_and_address_map_test;
  import cpfam_pkg::*;
  typedef struct packed { logic [19:0] a; logic [2:0] r; logic v; } cpfam_row_t;
  logic sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, flg_wr = 1'b0;
  logic flg_u = 1'b0, flg_ie = 1'b0, irq_req = 1'b0, trap_exec = 1'b0;
  logic act_sp_wr = 1'b0, isp_wr = 1'b0, usp_wr = 1'b0;
  logic [19:0] reg_addr = 20'h00000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, mem_rdata, dac0_value, dac1_value, dac_ctrl;
  logic [2:0]  flg_ipl = 3'h0, irq_prio = 3'h0, flag_ipl;
  logic [5:0]  trap_num = 6'h00;
  logic [15:0] sp_wdata = 16'h0000, active_sp, pullup_ctrl;
  logic [55:0] port_din = 56'h99, port_dout, port_oe;
  logic mem_vector, mem_wr, mem_rd, irq_ack, sp_in_ram, flag_u, flag_ie, flag_rsv;
  cpfam_region_t mem_region;
  int miscompares = 0, checks = 0, cycles = 0;
  cpfam_row_t rows [16] = '{
    '{20'h00000, REG_SFR, 1'b0}, '{20'h002ff, REG_SFR, 1'b0}, '{20'h00300, REG_NONE, 1'b0},
    '{20'h00400, REG_RAM, 1'b0}, '{20'h00dff, REG_RAM, 1'b0}, '{20'h00e00, REG_NONE, 1'b0},
    '{20'h02400, REG_FLASH, 1'b0}, '{20'h02bff, REG_FLASH, 1'b0},
    '{20'h02c00, REG_NONE, 1'b0}, '{20'h03fff, REG_NONE, 1'b0}, '{20'h04000, REG_ROM, 1'b0},
    '{20'h0ffdb, REG_ROM, 1'b0}, '{20'h0ffdc, REG_ROM, 1'b1}, '{20'h0ffff, REG_ROM, 1'b1},
    '{20'h10000, REG_NONE, 1'b0}, '{20'hfffff, REG_NONE, 1'b0}};
  logic [9:0] regs [18] = '{10'h0d8, 10'h0da, 10'h0dc, 10'h0e2, 10'h0e3, 10'h0e6, 10'h0e7,
    10'h0ea, 10'h0eb, 10'h0ee, 10'h0f4, 10'h0f5, 10'h0f8, 10'h0f9, 10'h0fa, 10'h0fb,
    10'h0fc, 10'h0fd};

  always #5 sys_clk = ~sys_clk;

  cpfam_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_region(mem_region), .mem_vector(mem_vector), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .flg_wr(flg_wr), .flg_u(flg_u), .flg_ie(flg_ie),
    .flg_ipl(flg_ipl), .irq_req(irq_req), .irq_prio(irq_prio), .irq_ack(irq_ack),
    .trap_exec(trap_exec), .trap_num(trap_num), .act_sp_wr(act_sp_wr), .isp_wr(isp_wr),
    .usp_wr(usp_wr), .sp_wdata(sp_wdata), .active_sp(active_sp), .sp_in_ram(sp_in_ram),
    .flag_u(flag_u), .flag_ie(flag_ie), .flag_ipl(flag_ipl), .flag_rsv(flag_rsv),
    .port_din(port_din), .port_dout(port_dout), .port_oe(port_oe),
    .dac0_value(dac0_value), .dac1_value(dac1_value), .dac_ctrl(dac_ctrl),
    .pullup_ctrl(pullup_ctrl));

  cpfam_mem_model mem (.sys_clk(sys_clk), .addr(reg_addr), .wdata(reg_wdata),
    .wr(mem_wr), .rd(mem_rd), .rdata(mem_rdata));

  task automatic chk(string n, logic [55:0] e, logic [55:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [19:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [19:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("read data", e, reg_rdata);
  endtask

  task automatic flags(logic u, logic ie, logic [2:0] processor_priority_level);
    @(posedge sys_clk);
    flg_wr <= 1'b1; flg_u <= u; flg_ie <= ie; flg_ipl <= processor_priority_level;
    @(posedge sys_clk);
    flg_wr <= 1'b0;
  endtask

  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize;
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    #1 chk("flag_u", 0, flag_u);
    chk("flag_rsv", 0, flag_rsv);
    chk("port_oe", 0, port_oe);
    foreach (rows[i]) begin
      @(posedge sys_clk);
      reg_addr <= rows[i].a;
      #1 chk("region", rows[i].r, mem_region);
      chk("vector", rows[i].v, mem_vector);
    end
    foreach (regs[i]) begin
      rd({10'h000, regs[i]}, 8'h00);
      wr({10'h000, regs[i]}, regs[i][7:0] ^ 8'ha5);
      rd({10'h000, regs[i]}, regs[i][7:0] ^ 8'ha5);
    end
    chk("dac0", 8'h7d, dac0_value);
    chk("dir0", 8'h47, port_oe[7:0]);
    chk("dac1", 8'h7f, dac1_value);
    chk("dac ctrl", 8'h79, dac_ctrl);
    chk("pullups", 16'h5859, pullup_ctrl);
    chk("dirs", 56'h4b4e4f42434647, port_oe);
    wr(20'h000e0, 8'h3c);
    #1 chk("port0", 8'h3c, port_dout[7:0]);
    rd(20'h000e0, 8'h3c & 8'h47 | 8'h99 & 8'hb8);
    wr(20'h00300, 8'hff);
    rd(20'h00300, 8'h00);
    wr(20'h10000, 8'hff);
    rd(20'h10000, 8'h00);
    wr(20'h00400, 8'h77);
    rd(20'h00400, 8'h77);
    wr(20'h02405, 8'hee);
    rd(20'h02405, 8'h05);
    @(posedge sys_clk);
    isp_wr <= 1'b1; sp_wdata <= 16'h0500;
    @(posedge sys_clk);
    isp_wr <= 1'b0; usp_wr <= 1'b1; sp_wdata <= 16'h0600;
    @(posedge sys_clk);
    usp_wr <= 1'b0;
    flags(1'b1, 1'b1, 3'h7);
    #1 chk("ipl", 3'h7, flag_ipl);
    chk("active_sp", 16'h0600, active_sp);
    chk("sp_in_ram", 1, sp_in_ram);
    irq_req <= 1'b1; irq_prio <= 3'h7;
    #1 chk("ack equal", 0, irq_ack);
    flags(1'b1, 1'b1, 3'h2);
    irq_prio <= 3'h2;
    #1 chk("ack same", 0, irq_ack);
    @(posedge sys_clk);
    irq_prio <= 3'h3;
    #1 chk("ack higher", 1, irq_ack);
    @(posedge sys_clk);
    irq_req <= 1'b0;
    #1 chk("u after ack", 0, flag_u);
    chk("ie after ack", 0, flag_ie);
    chk("isp used", 16'h0500, active_sp);
    chk("ipl kept", 3'h2, flag_ipl);
    flags(1'b1, 1'b0, 3'h0);
    irq_req <= 1'b1; irq_prio <= 3'h7;
    #1 chk("ack masked", 0, irq_ack);
    @(posedge sys_clk);
    irq_req <= 1'b0; trap_exec <= 1'b1; trap_num <= 6'h20;
    @(posedge sys_clk);
    trap_exec <= 1'b0;
    #1 chk("trap 32", 1, flag_u);
    @(posedge sys_clk);
    trap_exec <= 1'b1; trap_num <= 6'h1f;
    @(posedge sys_clk);
    trap_exec <= 1'b0;
    #1 chk("trap 31", 0, flag_u);
    @(posedge sys_clk);
    act_sp_wr <= 1'b1; sp_wdata <= 16'h0700;
    @(posedge sys_clk);
    act_sp_wr <= 1'b0;
    #1 chk("act write", 16'h0700, active_sp);
    flags(1'b1, 1'b0, 3'h0);
    #1 chk("usp kept", 16'h0600, active_sp);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= 20'h000e3; reg_wdata <= 8'h5a;
    @(posedge sys_clk);
    reg_wr <= 1'b0; reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("dir1 back to back", 8'h5a, reg_rdata);
    repeat (2) @(posedge sys_clk);
    summarize;
  end
endmodule // cpu_flag_and_address_map_test
